// File: rtl/uart_status_interrupt_unit.sv
// Status, input selection, loop-back and interrupt logic of the UART
//
// What this block does
// R1: Control bits 7-6 pick receive input: 00 LIN receiver, 10 general pin.
// R2: Loop-back bit 4 enters loop-back and forces transmit pin high.
// R3: Transmitter-empty bit 6 set when holding and shift empty; write clears.
// R4: Holding-empty bit 5 set once holding register empties; write clears.
// R5: Break bit 4 set when input low beyond maximum word; status read clears.
// R6: Framing error bit 3 set on an invalid stop bit.
// R7: Parity error bit 2 set on a failed parity check.
// R8: Overrun bit 1 set when an unread character is overwritten.
// R9: Data-ready bit 0 set while a character waits; receive read clears.
// R10: Enable bit 2 raises an interrupt when status bits 4:0 set.
// R11: Enable bit 1 raises an interrupt when holding-empty is set.
// R12: Enable bit 0 raises an interrupt when the receive register fills.
// R13: Software writes zero to reserved enable bit 3.
// R14: Identification: bit 0 high when idle, else code 11,10,01,00 by priority.
// R15: Transmit-empty interrupt cleared by holding write or identification read.
// R16: Line interrupt cleared by status read; modem by modem status read.
// R17: Enable register reachable only while divisor latch access bit clear.
// R18: Highest pending source shown; request held while any unmasked source pends.
//
// Decided for this implementation: the strobed register port.
`timescale 1ns/1ps
`include "uart_status_params.svh"

module uart_status_interrupt_unit (
   input  wire logic        ref_clk_in,
   input  wire logic        rst_b_in,
   input  wire logic [31:0] addr_in,
   input  wire logic [7:0]  wr_data_in,
   input  wire logic        wr_in,
   input  wire logic        rd_in,
   output logic      [7:0]  rd_data_out,
   input  wire logic        lin_rx_in,
   input  wire logic        general_pin_five_in,
   input  wire logic        tx_serial_in,
   input  wire logic        tx_taken_in,
   input  wire logic        tx_shift_empty_in,
   input  wire logic        bit_tick_in,
   input  wire logic        rx_char_done_in,
   input  wire logic [7:0]  rx_char_in,
   input  wire logic        rx_frame_err_in,
   input  wire logic        rx_parity_err_in,
   input  wire logic [7:0]  modem_status_in,
   input  wire logic        modem_change_in,
   output logic             serial_line_input_out,
   output logic             txd_out,
   output logic      [7:0]  tx_data_out,
   output logic             tx_valid_out,
   output logic      [15:0] divisor_out,
   output logic      [7:0]  line_control_out,
   output logic             irq_out
);
   import uart_status_pkg::*;

   // ==========================================================
   // Register state
   logic [7:0] ien_q;
   logic [7:0] muxloop_q;
   logic [7:0] lcr0_q;
   logic [7:0] div_lo_q;
   logic [7:0] div_hi_q;
   logic [7:0] rx_buf_q;
   logic [7:0] tx_hold_q;
   logic       holding_empty_flag_q;
   logic       transmitter_empty_flag_q;
   logic       bi_q;
   logic       fe_q;
   logic       pe_q;
   logic       oe_q;
   logic       dr_q;
   logic       line_pend_q;
   logic       tx_pend_q;
   logic       modem_pend_q;
   logic [3:0] evt_q;
   logic [3:0] evt_mask_q;
   logic [3:0] low_cnt_q;
   logic       brk_seen_q;
   logic       rx_line;

   // ==========================================================
   // Access decode
   logic       divisor_latch_access_bit;
   logic       wr_thr;
   logic       rd_rbr;
   logic       rd_lsr;
   logic       rd_msr;
   logic       rd_iid;
   logic       rd_evt;
   logic       wr_ien;

   function automatic logic hit(input logic [31:0] a,
                                input logic [31:0] ofs);
      hit = (a == ofs);
   endfunction

   assign divisor_latch_access_bit   = lcr0_q[`DIVISOR_LATCH_ACCESS_BIT_BIT];
   assign wr_thr = wr_in & hit(addr_in, `OFS_DATA) & ~divisor_latch_access_bit;
   assign rd_rbr = rd_in & hit(addr_in, `OFS_DATA) & ~divisor_latch_access_bit;
   assign wr_ien = wr_in & hit(addr_in, `OFS_IEN) & ~divisor_latch_access_bit;  // R17
   assign rd_lsr = rd_in & hit(addr_in, `OFS_LSR);
   assign rd_msr = rd_in & hit(addr_in, `OFS_MSR);
   assign rd_iid = rd_in & hit(addr_in, `OFS_IID);
   assign rd_evt = rd_in & hit(addr_in, `OFS_EVT_STAT);

   // ==========================================================
   // Control registers
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ien_q     <= `RST_IEN;
         muxloop_q <= `RST_MUXLOOP;
         lcr0_q    <= `RST_LCR0;
         div_lo_q  <= 8'h00;
         div_hi_q  <= 8'h00;
         evt_mask_q <= `RST_EVT_MASK;
      end else if (wr_in) begin
         if (wr_ien) begin
            ien_q <= wr_data_in;  // R13
         end
         if (hit(addr_in, `OFS_IEN) & divisor_latch_access_bit) begin
            div_hi_q <= wr_data_in;
         end
         if (hit(addr_in, `OFS_DATA) & divisor_latch_access_bit) begin
            div_lo_q <= wr_data_in;
         end
         if (hit(addr_in, `OFS_LCR0)) begin
            lcr0_q <= wr_data_in;
         end
         if (hit(addr_in, `OFS_MUXLOOP)) begin
            muxloop_q <= wr_data_in;
         end
         if (hit(addr_in, `OFS_EVT_MASK)) begin
            evt_mask_q <= wr_data_in[3:0];
         end
      end
   end

   // ==========================================================
   // Receive input selection and pin drive
   logic loop_en;
   assign loop_en = muxloop_q[`LOOP_BIT];

   always_comb begin
      case (rx_src_t'(muxloop_q[`MUX_HI:`MUX_LO]))
         SRC_LIN:  rx_line = lin_rx_in;  // R1
         SRC_GPIN: rx_line = general_pin_five_in;  // R1
         // Reserved codes hold the receiver at idle
         default:  rx_line = 1'b1;
      endcase
      if (loop_en) begin
         rx_line = tx_serial_in;  // R2
      end
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         serial_line_input_out <= 1'b1;
         txd_out               <= 1'b1;
      end else begin
         serial_line_input_out <= rx_line;
         if (loop_en) begin
            txd_out <= 1'b1;  // R2
         end else if (lcr0_q[`BREAK_TX_BIT]) begin
            txd_out <= 1'b0;
         end else begin
            txd_out <= tx_serial_in;
         end
      end
   end

   // ==========================================================
   // Transmit holding register and empty flags
   logic holding_empty_flag_d;
   localparam logic [7:0] lsr_rst_val = `RST_LSR;
   // A write in the same cycle as a take loads fresh data, so it wins
   assign holding_empty_flag_d = wr_thr ? 1'b0 : (tx_taken_in ? 1'b1 : holding_empty_flag_q);

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tx_hold_q <= 8'h00;
         holding_empty_flag_q    <= lsr_rst_val[`HOLDING_EMPTY_FLAG_BIT];
         transmitter_empty_flag_q    <= lsr_rst_val[`TRANSMITTER_EMPTY_FLAG_BIT];
      end else begin
         if (wr_thr) begin
            tx_hold_q <= wr_data_in;
         end
         holding_empty_flag_q <= holding_empty_flag_d;  // R4
         transmitter_empty_flag_q <= holding_empty_flag_d & tx_shift_empty_in & ~wr_thr;  // R3
      end
   end

   // ==========================================================
   // Break detection on the selected input
   // Counts bit times while low; one report per low stretch
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         low_cnt_q  <= 4'h0;
         brk_seen_q <= 1'b0;
      end else if (rx_line) begin
         low_cnt_q  <= 4'h0;
         brk_seen_q <= 1'b0;
      end else if (bit_tick_in) begin
         if (low_cnt_q != 4'hF) begin
            low_cnt_q <= low_cnt_q + 4'h1;
         end
         if (low_cnt_q >= `MAX_WORD_BITS) begin
            brk_seen_q <= 1'b1;
         end
      end
   end

   logic brk_set;
   assign brk_set = bit_tick_in & ~rx_line & ~brk_seen_q
                  & (low_cnt_q >= `MAX_WORD_BITS);  // R5

   // ==========================================================
   // Receive buffer and line status flags
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rx_buf_q <= 8'h00;
         dr_q     <= 1'b0;
         oe_q     <= 1'b0;
         fe_q     <= 1'b0;
         pe_q     <= 1'b0;
         bi_q     <= 1'b0;
      end else begin
         if (rx_char_done_in) begin
            rx_buf_q <= rx_char_in;
         end
         // Set wins over the clearing read
         dr_q <= rx_char_done_in | (dr_q & ~rd_rbr);  // R9
         oe_q <= (rx_char_done_in & dr_q & ~rd_rbr)
               | (oe_q & ~rd_lsr);  // R8
         fe_q <= (rx_char_done_in & rx_frame_err_in)
               | (fe_q & ~rd_lsr);  // R6
         pe_q <= (rx_char_done_in & rx_parity_err_in)
               | (pe_q & ~rd_lsr);  // R7
         bi_q <= brk_set | (bi_q & ~rd_lsr);  // R5
      end
   end

   logic [7:0] lsr;
   assign lsr = {1'b0, transmitter_empty_flag_q, holding_empty_flag_q, bi_q, fe_q, pe_q, oe_q, dr_q};

   // ==========================================================
   // Interrupt sources
   logic line_set;
   logic tx_set;
   logic rx_pend;
   logic line_pend;
   logic tx_pend;
   logic modem_pend;

   assign line_set = ien_q[`IEN_LINE] & ((rx_char_done_in & ~dr_q)
                   | (rx_char_done_in & (rx_frame_err_in
                   | rx_parity_err_in | dr_q)) | brk_set);  // R10
   // Rising holding-empty, or the enable written while already empty
   assign tx_set = (tx_taken_in & ~holding_empty_flag_q & ~wr_thr)
                 | (wr_ien & wr_data_in[`IEN_TX] & holding_empty_flag_q);  // R11

   assign rx_pend    = ien_q[`IEN_RX] & dr_q;  // R12
   assign line_pend  = line_pend_q & ien_q[`IEN_LINE];
   assign tx_pend    = tx_pend_q & ien_q[`IEN_TX] & holding_empty_flag_q;
   assign modem_pend = modem_pend_q & ien_q[`IEN_MODEM];

   logic [7:0] iid;
   always_comb begin
      iid = `RST_IID;
      if (line_pend) begin
         iid = {5'h00, IID_LINE, 1'b0};  // R14
      end else if (rx_pend) begin
         iid = {5'h00, IID_RX, 1'b0};  // R14
      end else if (tx_pend) begin
         iid = {5'h00, IID_TX, 1'b0};  // R14
      end else if (modem_pend) begin
         iid = {5'h00, IID_MODEM, 1'b0};  // R18
      end
   end

   logic iid_shows_tx;
   assign iid_shows_tx = ~iid[0] & (iid[2:1] == IID_TX);

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         line_pend_q  <= 1'b0;
         tx_pend_q    <= 1'b0;
         modem_pend_q <= 1'b0;
      end else begin
         line_pend_q  <= line_set | (line_pend_q & ~rd_lsr);  // R16
         tx_pend_q    <= tx_set | (tx_pend_q & ~wr_thr
                       & ~(rd_iid & iid_shows_tx));  // R15
         modem_pend_q <= modem_change_in
                       | (modem_pend_q & ~rd_msr);  // R16
      end
   end

   // ==========================================================
   // Sticky event status, mask and request output
   logic [3:0] src_now;
   assign src_now = {modem_pend, tx_pend, rx_pend, line_pend};

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         evt_q   <= 4'h0;
         irq_out <= 1'b0;
      end else begin
         // A still-pending source sets its bit again after the read
         evt_q   <= src_now | (evt_q & ~{4{rd_evt}});
         irq_out <= |((src_now | (evt_q & ~{4{rd_evt}}))
                    & evt_mask_q);  // R18
      end
   end

   // ==========================================================
   // Read data, one cycle after the strobe
   logic [7:0] rd_mux;
   always_comb begin
      rd_mux = 8'h00;
      case (addr_in)
         `OFS_DATA:     rd_mux = divisor_latch_access_bit ? div_lo_q : rx_buf_q;
         `OFS_IEN:      rd_mux = divisor_latch_access_bit ? div_hi_q : ien_q;  // R17
         `OFS_IID:      rd_mux = iid;
         `OFS_LCR0:     rd_mux = lcr0_q;
         `OFS_MUXLOOP:  rd_mux = muxloop_q;
         `OFS_LSR:      rd_mux = lsr;
         `OFS_MSR:      rd_mux = modem_status_in;
         `OFS_EVT_STAT: rd_mux = {4'h0, evt_q};
         `OFS_EVT_MASK: rd_mux = {4'h0, evt_mask_q};
         default:       rd_mux = 8'h00;
      endcase
   end

   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         rd_data_out <= 8'h00;
      end else if (rd_in) begin
         rd_data_out <= rd_mux;
      end else begin
         rd_data_out <= 8'h00;
      end
   end

   // ==========================================================
   // Outputs toward transmitter and baud generator
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         tx_data_out      <= 8'h00;
         tx_valid_out     <= 1'b0;
         divisor_out      <= 16'h0000;
         line_control_out <= `RST_LCR0;
      end else begin
         tx_data_out      <= wr_thr ? wr_data_in : tx_hold_q;
         tx_valid_out     <= ~holding_empty_flag_d;
         divisor_out      <= {div_hi_q, div_lo_q};
         line_control_out <= lcr0_q;
      end
   end

endmodule // uart_status_interrupt_unit

// File: rtl/uart_status_params.svh
// Offsets, field positions, reset values and counts of the status unit
`ifndef UART_STATUS_PARAMS_SVH
`define UART_STATUS_PARAMS_SVH

// ==========================================================
// Register offsets
`define OFS_DATA      32'hFFFF0700
`define OFS_IEN       32'hFFFF0704
`define OFS_IID       32'hFFFF0708
`define OFS_LCR0      32'hFFFF070C
`define OFS_MUXLOOP   32'hFFFF0710
`define OFS_LSR       32'hFFFF0714
`define OFS_MSR       32'hFFFF0718
`define OFS_EVT_STAT  32'hFFFF071C
`define OFS_EVT_MASK  32'hFFFF0720

// ==========================================================
// Field positions
`define DIVISOR_LATCH_ACCESS_BIT_BIT      7
`define BREAK_TX_BIT  6
`define LOOP_BIT      4
`define MUX_HI        7
`define MUX_LO        6
`define TRANSMITTER_EMPTY_FLAG_BIT      6
`define HOLDING_EMPTY_FLAG_BIT      5
`define BI_BIT        4
`define FE_BIT        3
`define PE_BIT        2
`define OE_BIT        1
`define DR_BIT        0
`define IEN_MODEM     3
`define IEN_LINE      2
`define IEN_TX        1
`define IEN_RX        0

// ==========================================================
// Reset values and counts
`define RST_IEN       8'h00
`define RST_IID       8'h01
`define RST_MUXLOOP   8'h00
`define RST_LSR       8'h60
`define RST_LCR0      8'h00
`define RST_EVT_MASK  4'hF
`define MAX_WORD_BITS 4'hC

`endif

// File: rtl/uart_status_pkg.sv
// Types shared by the status and interrupt unit
package uart_status_pkg;

   // ==========================================================
   // Identification codes, highest priority first
   typedef enum logic [1:0] {
      IID_LINE  = 2'b11,
      IID_RX    = 2'b10,
      IID_TX    = 2'b01,
      IID_MODEM = 2'b00
   } iid_code_t;

   // ==========================================================
   // Receive input selection
   typedef enum logic [1:0] {
      SRC_LIN  = 2'b00,
      SRC_RSV1 = 2'b01,
      SRC_GPIN = 2'b10,
      SRC_RSV3 = 2'b11
   } rx_src_t;

endpackage

// File: sim/uart_status_chk.sv
// Port-level checks of the status and interrupt unit
`timescale 1ns/1ps
`include "uart_status_params.svh"

module uart_status_chk (
   input wire logic        ref_clk_in,
   input wire logic        rst_b_in,
   input wire logic [31:0] addr_in,
   input wire logic [7:0]  wr_data_in,
   input wire logic        wr_in,
   input wire logic        rd_in,
   input wire logic [7:0]  rd_data_out,
   input wire logic        lin_rx_in,
   input wire logic        general_pin_five_in,
   input wire logic        tx_taken_in,
   input wire logic        rx_char_done_in,
   input wire logic        serial_line_input_out,
   input wire logic        txd_out,
   input wire logic [7:0]  tx_data_out,
   input wire logic        tx_valid_out,
   input wire logic [15:0] divisor_out,
   input wire logic        irq_out
);
   logic [7:0] ctl_q;
   logic [3:0] ien_q;
   logic [3:0] msk_q;
   logic       divisor_latch_access_bit_q;
   wire  [7:0] div_hi = divisor_out[15:8];

   // ==========================================================
   // Shadows of control writes, so checks need no internal taps
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         ctl_q  <= `RST_MUXLOOP;
         ien_q  <= 4'h0;
         msk_q  <= `RST_EVT_MASK;
         divisor_latch_access_bit_q <= 1'b0;
      end else if (wr_in) begin
         if (addr_in == `OFS_MUXLOOP) ctl_q <= wr_data_in;
         if (addr_in == `OFS_IEN && !divisor_latch_access_bit_q) ien_q <= wr_data_in[3:0];
         if (addr_in == `OFS_EVT_MASK) msk_q <= wr_data_in[3:0];
         if (addr_in == `OFS_LCR0) divisor_latch_access_bit_q <= wr_data_in[`DIVISOR_LATCH_ACCESS_BIT_BIT];
      end
   end

   default clocking @(posedge ref_clk_in); endclocking
   default disable iff (!rst_b_in);

   // ==========================================================
   // Assertions
   sel_lin_a:
   assert property (ctl_q[7:6] == 2'b00 && !ctl_q[4]
      |=> serial_line_input_out == $past(lin_rx_in))
      else $error("receive line not from LIN input");
   sel_gpin_a:
   assert property (ctl_q[7:6] == 2'b10 && !ctl_q[4]
      |=> serial_line_input_out == $past(general_pin_five_in))
      else $error("receive line not from general pin");
   loop_high_a:
   assert property (ctl_q[4] |=> txd_out)
      else $error("transmit pin low in loop-back");
   tx_load_a:
   assert property (wr_in && addr_in == `OFS_DATA && !divisor_latch_access_bit_q
      |=> tx_valid_out && tx_data_out == $past(wr_data_in))
      else $error("holding write not taken");
   tx_take_a:
   assert property (tx_taken_in && !wr_in |=> !tx_valid_out)
      else $error("holding still full after hand-over");
   transmitter_empty_flag_holding_empty_flag_a:
   assert property (rd_in && addr_in == `OFS_LSR
      |=> !rd_data_out[6] || rd_data_out[5])
      else $error("shift empty shown with holding full");
   iid_idle_a:
   assert property (rd_in && addr_in == `OFS_IID
      |=> !rd_data_out[0] || rd_data_out[2:1] == 2'b00)
      else $error("idle ident with nonzero code");
   // Divisor port lags its register a cycle, so it matches at the read data
   div_read_a:
   assert property (rd_in && addr_in == `OFS_IEN && divisor_latch_access_bit_q
      |=> rd_data_out == div_hi)
      else $error("divisor high byte not read back");
   ien_read_a:
   assert property (rd_in && addr_in == `OFS_IEN && !divisor_latch_access_bit_q
      |=> rd_data_out[3:0] == $past(ien_q))
      else $error("enable register not read back");
   rx_irq_a:
   assert property (rx_char_done_in && ien_q[0] && msk_q[1]
      |-> ##[1:3] irq_out)
      else $error("no interrupt on receive full");
   irq_hold_a:
   assert property (irq_out && !rd_in && !wr_in |=> irq_out)
      else $error("interrupt dropped with no access");

   cover property (irq_out && rd_in);
   cover property (tx_taken_in && tx_valid_out);
   cover property (ctl_q[7:6] == 2'b10 && !general_pin_five_in);
endmodule // uart_status_chk

bind uart_status_interrupt_unit uart_status_chk i_uart_status_chk (
   .ref_clk_in, .rst_b_in, .addr_in, .wr_data_in, .wr_in, .rd_in,
   .rd_data_out, .lin_rx_in, .general_pin_five_in, .tx_taken_in,
   .rx_char_done_in, .serial_line_input_out, .txd_out, .tx_data_out,
   .tx_valid_out, .divisor_out, .irq_out
);

// File: sim/line_partner.sv
// Far-side model: LIN transceiver output, general pin and bit ticks
`timescale 1ns/1ps

module line_partner (
   input  wire logic ref_clk_in,
   input  wire logic rst_b_in,
   input  wire logic lin_lvl_in,
   input  wire logic gp_lvl_in,
   input  wire logic brk_in,
   output logic      lin_rx_out,
   output logic      gp_out,
   output logic      tick_out
);
   logic [1:0] div_q;

   // ==========================================================
   // Lines idle high; a break holds the general pin low
   always_ff @(posedge ref_clk_in or negedge rst_b_in) begin
      if (!rst_b_in) begin
         lin_rx_out <= 1'b1;
         gp_out     <= 1'b1;
         div_q      <= 2'h0;
         tick_out   <= 1'b0;
      end else begin
         lin_rx_out <= lin_lvl_in;
         gp_out     <= gp_lvl_in && !brk_in;
         div_q      <= div_q + 2'h1;
         tick_out   <= div_q == 2'h3;
      end
   end
endmodule // line_partner

// File: sim/uart_status_interrupt_unit_bench.sv
// Self-checking bench of the status and interrupt unit
`timescale 1ns/1ps
`include "uart_status_params.svh"

module uart_status_interrupt_unit_bench;
   import uart_status_pkg::*;
   logic        clk, rst_b, wr, rd, txs, tkn, sem, rxd, fe, pe, mch;
   logic        lin_l, gp_l, brk, lin, gp, tick, sli, txd, txv, irq;
   logic [31:0] addr;
   logic [7:0]  wd, rdat, rxc, txdat, lcr, got;
   logic [15:0] dv;
   logic [1:0]  code;
   integer      err_count, cmp_count, seed, i;

   uart_status_interrupt_unit i_uart_status_interrupt_unit (
      .ref_clk_in(clk), .rst_b_in(rst_b), .addr_in(addr),
      .wr_data_in(wd), .wr_in(wr), .rd_in(rd), .rd_data_out(rdat),
      .lin_rx_in(lin), .general_pin_five_in(gp), .tx_serial_in(txs),
      .tx_taken_in(tkn), .tx_shift_empty_in(sem), .bit_tick_in(tick),
      .rx_char_done_in(rxd), .rx_char_in(rxc), .rx_frame_err_in(fe),
      .rx_parity_err_in(pe), .modem_status_in(8'h5A),
      .modem_change_in(mch), .serial_line_input_out(sli),
      .txd_out(txd), .tx_data_out(txdat), .tx_valid_out(txv),
      .divisor_out(dv), .line_control_out(lcr), .irq_out(irq));

   line_partner i_line_partner (
      .ref_clk_in(clk), .rst_b_in(rst_b), .lin_lvl_in(lin_l),
      .gp_lvl_in(gp_l), .brk_in(brk), .lin_rx_out(lin),
      .gp_out(gp), .tick_out(tick));

   initial begin
      clk = 1'b0;
      forever #25 clk = ~clk;
   end

   // ==========================================================
   // Compare, bus and closing tasks
   task automatic chk8(input logic [7:0] g, input logic [7:0] x);
      cmp_count++;
      if (g !== x) begin
         err_count++;
         $display("MISMATCH %0t got %h expected %h", $time, g, x);
      end
   endtask

   task automatic chk1(input logic g, input logic x);
      chk8({7'h00, g}, {7'h00, x});
   endtask

   task automatic wr_reg(input logic [31:0] a, input logic [7:0] d);
      @(posedge clk);
      addr <= a;
      wd   <= d;
      wr   <= 1'b1;
      @(posedge clk);
      wr   <= 1'b0;
   endtask

   // Read data stands only in the cycle after the strobe
   task automatic rd_chk(input logic [31:0] a, input logic [7:0] x);
      @(posedge clk);
      addr <= a;
      rd   <= 1'b1;
      @(posedge clk);
      rd   <= 1'b0;
      #1 got = rdat;
      chk8(got, x);
   endtask

   task automatic rx_put(input logic [7:0] c, input logic f, input logic p);
      @(posedge clk);
      rxc <= c;
      fe  <= f;
      pe  <= p;
      rxd <= 1'b1;
      @(posedge clk);
      rxd <= 1'b0;
   endtask

   // Settle past each edge before looking, so no launch-edge race
   task automatic wait_irq(input logic x);
      #1;
      for (int n = 0; n < 8 && irq !== x; n++) begin
         @(posedge clk);
         #1;
      end
      chk1(irq, x);
   endtask

   function automatic logic exp_sel(input logic [1:0] c, input logic l,
                                    input logic g);
      return c == SRC_LIN ? l : (c == SRC_GPIN ? g : 1'b1);
   endfunction

   task automatic test_done;
      $display("Comparisons %0d mismatches %0d", cmp_count, err_count);
      if (err_count == 0 && cmp_count > 0) begin
         $display("Test passed");
      end else begin
         $display("Test failed");
      end
      $finish;
   endtask

   // Hang guard, far above the length of the run
   initial begin
      #100000;
      err_count++;
      test_done();
   end

   // ==========================================================
   // Main sequence
   initial begin
      {wr, rd, tkn, rxd, fe, pe, mch, brk} = 8'h00;
      {txs, sem, lin_l, gp_l} = 4'hF;
      addr = 32'h0;
      wd = 8'h00;
      rxc = 8'h00;
      err_count = 0;
      cmp_count = 0;
      seed = 33;
      rst_b = 1'b0;
      repeat (2) @(posedge clk);
      rst_b <= 1'b1;
      rd_chk(`OFS_IEN, `RST_IEN);
      rd_chk(`OFS_IID, `RST_IID);
      rd_chk(`OFS_MUXLOOP, `RST_MUXLOOP);
      rd_chk(`OFS_LSR, `RST_LSR);
      rd_chk(32'hFFFF0730, 8'h00);
      wr_reg(`OFS_MUXLOOP, 8'h80);
      brk <= 1'b1;
      repeat (70) @(posedge clk);
      brk <= 1'b0;
      rd_chk(`OFS_LSR, 8'h70);
      rd_chk(`OFS_LSR, 8'h60);
      for (i = 0; i < 12; i++) begin
         code = 2'(i);
         wr_reg(`OFS_MUXLOOP, {code, 6'h00});
         lin_l <= 1'($random(seed));
         gp_l  <= 1'($random(seed));
         repeat (3) @(posedge clk);
         #1 chk1(sli, exp_sel(code, lin_l, gp_l));
      end
      lin_l <= 1'b1;
      gp_l  <= 1'b1;
      txs   <= 1'b0;
      wr_reg(`OFS_MUXLOOP, 8'h10);
      repeat (2) @(posedge clk);
      #1 chk1(txd, 1'b1);
      wr_reg(`OFS_MUXLOOP, 8'h00);
      repeat (2) @(posedge clk);
      #1 chk1(txd, 1'b0);
      txs <= 1'b1;
      sem <= 1'b0;
      // Shift register busy, so only holding-empty stands
      rd_chk(`OFS_LSR, 8'h20);
      wr_reg(`OFS_DATA, 8'h3C);
      #1 chk8(txdat, 8'h3C);
      chk1(txv, 1'b1);
      rd_chk(`OFS_LSR, 8'h00);
      @(posedge clk);
      tkn <= 1'b1;
      @(posedge clk);
      tkn <= 1'b0;
      #1 chk1(txv, 1'b0);
      rd_chk(`OFS_LSR, 8'h20);
      sem <= 1'b1;
      rd_chk(`OFS_LSR, 8'h60);
      rx_put(8'hA5, 1'b1, 1'b0);
      rd_chk(`OFS_LSR, 8'h69);
      rx_put(8'h5A, 1'b0, 1'b1);
      rd_chk(`OFS_LSR, 8'h67);
      rd_chk(`OFS_DATA, 8'h5A);
      rd_chk(`OFS_LSR, 8'h60);
      wr_reg(`OFS_IEN, 8'h02);
      wait_irq(1'b1);
      rd_chk(`OFS_IID, 8'h02);
      rd_chk(`OFS_EVT_STAT, 8'h04);
      wait_irq(1'b0);
      wr_reg(`OFS_IEN, 8'h05);
      rx_put(8'h11, 1'b1, 1'b0);
      wait_irq(1'b1);
      rd_chk(`OFS_IID, 8'h06);
      rd_chk(`OFS_LSR, 8'h69);
      rd_chk(`OFS_IID, 8'h04);
      rd_chk(`OFS_DATA, 8'h11);
      rd_chk(`OFS_IID, 8'h01);
      rd_chk(`OFS_EVT_STAT, 8'h03);
      wait_irq(1'b0);
      // Masked source: pending shows in ident, no request
      wr_reg(`OFS_EVT_MASK, 8'h00);
      // Reserved modem enable stays zero, so a modem change shows nothing
      wr_reg(`OFS_IEN, 8'h02);
      @(posedge clk);
      mch <= 1'b1;
      @(posedge clk);
      mch <= 1'b0;
      wait_irq(1'b0);
      rd_chk(`OFS_IID, 8'h02);
      rd_chk(`OFS_MSR, 8'h5A);
      rd_chk(`OFS_IID, 8'h01);
      rd_chk(`OFS_EVT_STAT, 8'h04);
      wr_reg(`OFS_EVT_MASK, 8'h0F);
      wait_irq(1'b0);
      wr_reg(`OFS_LCR0, 8'h80);
      wr_reg(`OFS_IEN, 8'hC3);
      // Divisor port is registered once more behind the latch
      @(posedge clk);
      #1 chk8(dv[15:8], 8'hC3);
      rd_chk(`OFS_IEN, 8'hC3);
      wr_reg(`OFS_LCR0, 8'h00);
      @(posedge clk);
      #1 chk8(lcr, 8'h00);
      rd_chk(`OFS_IEN, 8'h02);
      test_done();
   end
endmodule // uart_status_interrupt_unit_bench
